// File: spc_ctl_model.sv
// Controller model for the serial power control port.
// Assumes the caller starts a transfer just after a clk edge.
module spc_ctl_model (
    output logic sclk = 1'b0, // Serial clock, still between words
    output logic sdat = 1'b0, // Serial data, no pull on the line
    output logic stb  = 1'b0  // Load strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shift n bits, bit 0 first, 160 ns per bit, then strobe if asked
    task automatic send(input logic [16:0] w, input int n, input logic ld);
        for (int i = 0; i < n; i++) begin
            sdat = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        // Released data never keeps its last value
        sdat = ~sdat;
        if (ld) begin
            #80 stb = 1'b1;
            #80 stb = 1'b0;
        end
    endtask : send
endmodule : spc_ctl_model

// File: spc_pkg.sv
// Constants for the serial power control port.
// Assumes one 50 MHz system clock; serial pins arrive asynchronously.
// Functional notes
// - Seventeen bits per transfer into holding register
// - Bit 0 first, bit 16 last
// - Strobe rising edge copies holding to operation
// - Bits 3..7 enable five radio sub-blocks
// - Each sub-block follows only its own bit
// - Synchronous port, one bit per serial clock
package spc_pkg;
    localparam int          SPC_WORD_BITS  = 17;     // Control word length
    localparam int          SPC_CNT_W      = 5;      // Bit counter width
    localparam int          SPC_EN_LSB     = 3;      // First enable bit
    localparam int          SPC_EN_NUM     = 5;      // Number of enable bits
    localparam logic [16:0] SPC_WORD_RESET = 17'h00000; // All blocks in standby
    localparam int          SPC_SYNC_STAGES = 2;     // Pin synchroniser depth
    localparam int          SPC_BIT_TXOSC  = 3;      // Transmit oscillator and buffer
    localparam int          SPC_BIT_TXMIX  = 4;      // Transmit mixer and LO buffer
    localparam int          SPC_BIT_MOD    = 5;      // Modulator
    localparam int          SPC_BIT_DRV    = 6;      // Driver amplifier
    localparam int          SPC_BIT_DIV2   = 7;      // Divide-by-two and limiter
endpackage : spc_pkg

// File: spc_port.sv
// Serial power control port: shifts a control word in from the pins,
// loads it on a strobe edge and drives five sub-block enables.
// Assumes serial clock, data and strobe are asynchronous to clk and
// the serial clock is several clk periods long in each phase.
module spc_port
    import spc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  ser_clk,
    input  wire logic                  ser_data,
    input  wire logic                  ser_strobe,
    output logic [SPC_EN_NUM-1:0]      blk_en,
    output logic [SPC_WORD_BITS-1:0]   op_word,
    output logic [SPC_CNT_W-1:0]       bit_count
);
    logic                     sclk_s;        // Synchronised serial clock
    logic                     sdata_s;       // Synchronised data
    logic                     strb_s;        // Synchronised strobe
    logic                     sclk_d_ff;     // Last serial clock level
    logic                     strb_d_ff;     // Last strobe level
    logic [SPC_WORD_BITS-1:0] hold_ff;       // Holding register
    logic [SPC_WORD_BITS-1:0] op_ff;         // Operation register
    logic [SPC_CNT_W-1:0]     cnt_ff;        // Bits shifted since load
    logic                     sclk_rise;     // Serial clock rising edge
    logic                     strb_rise;     // Strobe rising edge
    wire logic [SPC_EN_NUM-1:0] nxt_blk_en;  // Next sub-block enables

    // Timing from pin to output, in clk cycles: two cycles through the
    // synchroniser, one for the edge pulse to act on the registers and
    // one more for the output flops. Serial clock, data and strobe must
    // each hold a level for at least three clk cycles; shorter phases
    // may be missed. That is the price of sampling the link with the
    // system clock instead of clocking registers from the pin itself.

    // Each pin gets its own synchroniser before any logic looks at it
    spc_sync u_sync_clk (
        .clk    (clk),
        .resetn (resetn),
        .din    (ser_clk),
        .dout   (sclk_s)
    );
    spc_sync u_sync_dat (
        .clk    (clk),
        .resetn (resetn),
        .din    (ser_data),
        .dout   (sdata_s)
    );
    spc_sync u_sync_strb (
        .clk    (clk),
        .resetn (resetn),
        .din    (ser_strobe),
        .dout   (strb_s)
    );

    // Edge history, taken from the synchronised levels only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_ff <= 1'b0;
            strb_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            strb_d_ff <= strb_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign strb_rise = strb_s & ~strb_d_ff;

    // Shift right so bit 0 sent first ends in bit 0 after 17 clocks
    // Enables never see a half-shifted word: only this register moves
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_ff <= SPC_WORD_RESET;
        end else if (sclk_rise) begin
            hold_ff <= {sdata_s, hold_ff[SPC_WORD_BITS-1:1]};
        end
    end

    // Count shifted bits, cleared by a load; saturates to flag overruns
    // A count other than 17 at load time shows a short or long transfer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (strb_rise) begin
            cnt_ff <= '0;
        end else if (sclk_rise && cnt_ff != {SPC_CNT_W{1'b1}}) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Whole holding register copied on strobe; holding left intact
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_ff <= SPC_WORD_RESET;
        end else if (strb_rise) begin
            op_ff <= hold_ff;
        end
    end

    // Per sub-block next enable: each bit looks at its own operation bit
    // and nothing else, so any mix of blocks may run while others stand by.
    // Reserved positions drive no enable, whatever the controller sent; op_word still carries them.
    for (genvar g = 0; g < SPC_EN_NUM; g++) begin : g_enable
        assign nxt_blk_en[g] = op_ff[SPC_EN_LSB+g];
    end

    // Output flops; the extra cycle keeps every output straight off a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blk_en    <= '0;
            op_word   <= SPC_WORD_RESET;
            bit_count <= '0;
        end else begin
            blk_en    <= nxt_blk_en;
            op_word   <= op_ff;
            bit_count <= cnt_ff;
        end
    end

    // Checks on the port. Each is cut off while reset is low, so at the
    // first edge after release the sampled history holds reset values.

    // Enable follows operation bits one cycle after load
    AST_EN_FOLLOWS: assert property (@(posedge clk) disable iff (!resetn)
        blk_en == $past(op_ff[SPC_EN_LSB +: SPC_EN_NUM]))
        else $error("enable does not follow operation bits");

    // Operation register changes only on a strobe edge
    AST_OP_ONLY_STROBE: assert property (@(posedge clk) disable iff (!resetn)
        !strb_rise |=> $stable(op_ff))
        else $error("operation register changed without strobe");

    // Strobe edge loads holding value
    AST_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        strb_rise |=> op_ff == $past(hold_ff))
        else $error("strobe did not load holding register");

    // New bit enters at the top
    AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!resetn)
        sclk_rise |=> hold_ff[SPC_WORD_BITS-1] == $past(sdata_s))
        else $error("serial bit not shifted in");

    // Shift moves the word toward bit 0
    AST_SHIFT_DOWN: assert property (@(posedge clk) disable iff (!resetn)
        sclk_rise |=> hold_ff[SPC_WORD_BITS-2:0] == $past(hold_ff[SPC_WORD_BITS-1:1]))
        else $error("holding register did not shift");

    // No serial edge, no shift
    AST_HOLD_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        !sclk_rise |=> $stable(hold_ff))
        else $error("holding register moved without clock");

    // Enables two cycles after a load carry the loaded enable field only;
    // compared with the holding register so a wrong slice cannot hide
    AST_ENABLE_RANGE: assert property (@(posedge clk) disable iff (!resetn)
        strb_rise |-> ##2 blk_en == $past(hold_ff[SPC_EN_LSB +: SPC_EN_NUM], 2))
        else $error("enable mapping wrong");

    // Load restarts the bit count
    AST_COUNT_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        strb_rise |=> cnt_ff == '0)
        else $error("bit count not cleared");

    // Each named sub-block sits on its own enable output; these catch a
    // reversed or shifted enable field one block at a time, as the slice check also does
    AST_EN_TXOSC: assert property (@(posedge clk) disable iff (!resetn)
        blk_en[SPC_BIT_TXOSC-SPC_EN_LSB] == $past(op_ff[SPC_BIT_TXOSC]))
        else $error("oscillator enable wrong");

    // Transmit mixer enable
    AST_EN_TXMIX: assert property (@(posedge clk) disable iff (!resetn)
        blk_en[SPC_BIT_TXMIX-SPC_EN_LSB] == $past(op_ff[SPC_BIT_TXMIX]))
        else $error("mixer enable wrong");

    // Modulator enable
    AST_EN_MOD: assert property (@(posedge clk) disable iff (!resetn)
        blk_en[SPC_BIT_MOD-SPC_EN_LSB] == $past(op_ff[SPC_BIT_MOD]))
        else $error("modulator enable wrong");

    // Driver amplifier enable
    AST_EN_DRV: assert property (@(posedge clk) disable iff (!resetn)
        blk_en[SPC_BIT_DRV-SPC_EN_LSB] == $past(op_ff[SPC_BIT_DRV]))
        else $error("driver enable wrong");

    // Divide-by-two enable
    AST_EN_DIV2: assert property (@(posedge clk) disable iff (!resetn)
        blk_en[SPC_BIT_DIV2-SPC_EN_LSB] == $past(op_ff[SPC_BIT_DIV2]))
        else $error("divider enable wrong");

    // Every serial edge below the top of the range, without a strobe edge, adds exactly one bit
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!resetn)
        (sclk_rise && !strb_rise && cnt_ff != {SPC_CNT_W{1'b1}})
            |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("bit count did not step");

    // The count holds at its top; wrapping would hide an overrun
    AST_COUNT_SAT: assert property (@(posedge clk) disable iff (!resetn)
        (!strb_rise && cnt_ff == {SPC_CNT_W{1'b1}}) |=> cnt_ff == {SPC_CNT_W{1'b1}})
        else $error("bit count wrapped");

    // Word output mirrors the operation register one cycle later
    AST_WORD_MIRROR: assert property (@(posedge clk) disable iff (!resetn)
        op_word == $past(op_ff))
        else $error("word output does not follow operation register");

    // Count output mirrors the counter one cycle later
    AST_COUNT_MIRROR: assert property (@(posedge clk) disable iff (!resetn)
        bit_count == $past(cnt_ff))
        else $error("count output does not follow counter");

    // One serial clock edge gives one shift, never two
    AST_SCLK_ONE_SHOT: assert property (@(posedge clk) disable iff (!resetn)
        sclk_rise |=> !sclk_rise)
        else $error("serial edge pulse too long");

    // One strobe edge gives one load, never two
    AST_STRB_ONE_SHOT: assert property (@(posedge clk) disable iff (!resetn)
        strb_rise |=> !strb_rise)
        else $error("strobe edge pulse too long");

    // The whole word, reserved bits included, reaches the output after a load
    AST_LOAD_OUT: assert property (@(posedge clk) disable iff (!resetn)
        strb_rise |-> ##2 op_word == $past(hold_ff, 2))
        else $error("loaded word not on output");
endmodule : spc_port

// File: spc_port_tb.sv
// Self-checking bench for the serial power control port.
// Assumes spc_pkg and the controller model are compiled first.
module spc_port_tb
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk    = 1'b0; // 50 MHz clock
    logic                     resetn = 1'b0; // Reset, held 10 cycles
    logic                     sclk, sdat, stb; // Serial pins
    logic [SPC_EN_NUM-1:0]    blk_en;     // Sub-block enables
    logic [SPC_WORD_BITS-1:0] op_word;    // Operation register
    logic [SPC_CNT_W-1:0]     bit_count;  // Bits since last load
    logic [16:0]              w;          // Word under test
    int                       bad_count = 0;
    int                       checks = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
    always #10 clk = ~clk;
    spc_ctl_model ctl_u (.sclk(sclk), .sdat(sdat), .stb(stb));
    spc_port dut_u (.clk(clk), .resetn(resetn), .ser_clk(sclk), .ser_data(sdat),
        .ser_strobe(stb), .blk_en(blk_en), .op_word(op_word), .bit_count(bit_count));
    // Counts and verdict, the only way out of the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // One transfer, then six cycles, past the four-cycle output delay
    task automatic xfer(input logic [16:0] v, input int n, input logic ld);
        ctl_u.send(v, n, ld);
        repeat (6) @(posedge clk);
        #1;
    endtask : xfer
    // Watchdog: a hang counts as a mismatch
    initial begin
        #500000 bad_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("op_word", 17'h00000, op_word)
        `CHK("blk_en", 5'h00, blk_en)
        $display("test reset done");
        // One bit at each position shows order and reserved bits
        for (int i = 0; i < 17; i++) begin
            w = 17'h00001 << i;
            xfer(w, 17, 1'b1);
            `CHK("op_word", w, op_word)
            `CHK("blk_en", w[7:3], blk_en)
            `CHK("bit_count", 5'h00, bit_count)
        end
        $display("test walking bit done");
        // Shifting alone must not touch the operation register
        xfer(17'h1ffff, 17, 1'b0);
        `CHK("bit_count", 5'h11, bit_count)
        `CHK("op_word", 17'h10000, op_word)
        xfer(17'h00000, 0, 1'b1);
        `CHK("blk_en", 5'h1f, blk_en)
        xfer(17'h1ff57, 17, 1'b1);
        `CHK("blk_en", 5'h0a, blk_en)
        $display("test held load done");
        // Extra bits push the oldest out; the count stops at its top
        xfer(17'h1ffff, 17, 1'b0);
        xfer(17'h000a8, 17, 1'b0);
        `CHK("bit_count", 5'h1f, bit_count)
        xfer(17'h00000, 0, 1'b1);
        `CHK("op_word", 17'h000a8, op_word)
        `CHK("blk_en", 5'h15, blk_en)
        $display("test overrun done");
        // Reset in mid-run drops every block to standby, then a load works
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("op_word", SPC_WORD_RESET, op_word)
        `CHK("blk_en", 5'h00, blk_en)
        `CHK("bit_count", 5'h00, bit_count)
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        xfer(17'h000f8, 17, 1'b1);
        `CHK("op_word", 17'h000f8, op_word)
        `CHK("blk_en", 5'h1f, blk_en)
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : spc_port_tb

// File: spc_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is slow relative to clk.
module spc_sync
    import spc_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff; // First stage, read only by second stage

    // Plain double flop; metastability settles in the first stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : spc_sync
